// *** ireb_bank.sv ***
// Purpose: interrupt request flags, enable bank and cpu vector hand-off
// Assumes: classic wishbone slave, 32-bit data, word-aligned registers
// Notes:   port pin, low-voltage and comparator inputs are asynchronous
//
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module ireb_bank
  import ireb_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  // wishbone slave
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [13:0]      adr_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic [31:0]      dat_i,
  output logic [31:0]           dat_o,
  output logic                  ack_o,
  // sources
  input  wire logic [7:0]       port_pin,
  input  wire logic             low_voltage_detector,
  input  wire logic             comparator_out,
  input  wire ireb_periph_src_t periph_src,
  // cpu core
  output logic                  cpu_irq_req,
  output logic [3:0]            cpu_irq_vec,
  input  wire logic             cpu_irq_ack,
  // event interrupt
  output logic                  irq
);

  // register state
  logic [7:0]  periph_flags;
  logic [7:0]  port_flags;
  logic [7:0]  enable_high;
  logic [7:0]  enable_low;
  logic [2:0]  evt_status;
  logic [2:0]  evt_mask;
  logic        global_en;

  // synchronisers and edge memory
  logic [9:0]  sync1;
  logic [9:0]  sync2;
  logic [9:0]  sync_prev;
  logic [SYNC_STAGES:0] edge_arm;

  // two flops before any logic looks at pins
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1     <= '0;
      sync2     <= '0;
      sync_prev <= '0;
      edge_arm  <= '0;
    end else begin
      sync1     <= {comparator_out, low_voltage_detector, port_pin};
      sync2     <= sync1;
      sync_prev <= sync2;
      edge_arm  <= {edge_arm[SYNC_STAGES-1:0], 1'b1};
    end
  end

  // rising edges, held off until the chain refills after reset
  // (a pin already high at reset is a level, not an event)
  wire logic [9:0] rise     = (sync2 & ~sync_prev) & {10{edge_arm[SYNC_STAGES]}};
  wire logic [7:0] pin_rise = rise[7:0];
  wire logic       lv_rise  = rise[8];
  wire logic       cmp_rise = rise[9];

  // port flag set terms; shared sources merge into bits 7 and 6
  wire logic [7:0] port_set = {pin_rise[7] | lv_rise,
                               pin_rise[6] | cmp_rise,
                               pin_rise[5:0]};

  // peripheral flag set terms at their field positions
  wire logic [7:0] periph_set = {1'b0,
                                 periph_src.timer_b,
                                 periph_src.timer_a,
                                 periph_src.serial_rx,
                                 periph_src.serial_tx,
                                 2'b00,
                                 periph_src.converter};

  // bus decode
  wire logic [11:0] idx      = adr_i[13:2];
  wire logic        bus_req  = cyc_i & stb_i;
  wire logic        wr_take  = bus_req & ack_o & we_i & sel_i[0];
  wire logic        rd_take  = bus_req & ack_o & ~we_i;
  wire logic        wr_perf  = wr_take & (idx == IDX_PERIPH_FLAGS);
  wire logic        wr_port  = wr_take & (idx == IDX_PORT_FLAGS);
  wire logic        wr_enh   = wr_take & (idx == IDX_ENABLE_HIGH);
  wire logic        wr_enl   = wr_take & (idx == IDX_ENABLE_LOW);
  wire logic        wr_mask  = wr_take & (idx == IDX_EVT_MASK);
  wire logic        wr_ctrl  = wr_take & (idx == IDX_CONTROL);
  wire logic        rd_stat  = rd_take & (idx == IDX_EVT_STATUS);
  wire logic [7:0]  wbyte    = dat_i[7:0];

  // read mux; unmapped words read zero
  wire logic [7:0] rd_byte =
    (idx == IDX_PERIPH_FLAGS) ? periph_flags :
    (idx == IDX_ENABLE_HIGH)  ? enable_high :
    (idx == IDX_ENABLE_LOW)   ? enable_low :
    (idx == IDX_PORT_FLAGS)   ? port_flags :
    (idx == IDX_EVT_STATUS)   ? {5'h00, evt_status} :
    (idx == IDX_EVT_MASK)     ? {5'h00, evt_mask} :
    (idx == IDX_CONTROL)      ? {7'h00, global_en} : 8'h00;

  // arbitration inputs: peripheral flags 0..7, port flags 8..15
  wire logic [15:0] all_req = {port_flags, periph_flags};
  wire logic [31:0] all_lvl;
  ireb_pick_t       pick;

  // level per peripheral source from its enable pair; every port flag gets PORT_LEVEL
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_lvl
      assign all_lvl[2*g +: 2]      = {enable_high[g], enable_low[g]};
      assign all_lvl[16 + 2*g +: 2] = PORT_LEVEL;
    end
  endgenerate

  ireb_prio_arbiter u_arb (
    .req    (all_req),
    .levels (all_lvl),
    .pick   (pick)
  );

  // vector hand-off terms
  wire logic        vec_take   = cpu_irq_req & cpu_irq_ack;
  wire logic        vec_stale  = cpu_irq_req & ~all_req[cpu_irq_vec];
  wire logic        vec_load   = ~cpu_irq_req & global_en & pick.valid;
  wire logic [15:0] vec_clear  = vec_take ? (16'h0001 << cpu_irq_vec) : 16'h0000;

  // next flag values: software write, then hardware clear, set wins last
  wire logic [7:0] next_periph_flags =
    (((wr_perf ? wbyte : periph_flags) & ~vec_clear[7:0]) | periph_set) & PERIPH_USED;
  wire logic [7:0] next_port_flags =
    ((wr_port ? wbyte : port_flags) & ~vec_clear[15:8]) | port_set;

  // event terms; a read clears only the bits it returned
  wire logic [2:0] evt_set = {vec_take, |periph_set, |port_set};
  wire logic [2:0] next_evt_status =
    (evt_status & ~(rd_stat ? dat_o[2:0] : 3'h0)) | evt_set;

  // request flags
  always_ff @(posedge clk) begin
    if (rst) begin
      periph_flags <= RST_FLAGS;
      port_flags   <= RST_FLAGS;
    end else begin
      periph_flags <= next_periph_flags;
      port_flags   <= next_port_flags;
    end
  end

  // enable bank and control
  always_ff @(posedge clk) begin
    if (rst) begin
      enable_high <= RST_ENABLE;
      enable_low  <= RST_ENABLE;
      global_en   <= RST_CTRL;
    end else begin
      if (wr_enh) enable_high <= wbyte;
      if (wr_enl) enable_low  <= wbyte & ENABLE_LOW_RW;
      if (wr_ctrl) global_en  <= wbyte[0];
    end
  end

  // event status, mask and interrupt line
  always_ff @(posedge clk) begin
    if (rst) begin
      evt_status <= RST_EVT;
      evt_mask   <= RST_EVT;
      irq        <= 1'b0;
    end else begin
      evt_status <= next_evt_status;
      if (wr_mask) evt_mask <= wbyte[2:0];
      irq        <= |(next_evt_status & (wr_mask ? wbyte[2:0] : evt_mask));
    end
  end

  // wishbone answer: ack one cycle after the request, then drop
  always_ff @(posedge clk) begin
    if (rst) begin
      ack_o <= 1'b0;
      dat_o <= '0;
    end else begin
      ack_o <= bus_req & ~ack_o;
      if (bus_req & ~ack_o) dat_o <= {24'h000000, rd_byte};
    end
  end

  // vector register: held until taken, disabled or cleared by software
  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_irq_req <= 1'b0;
      cpu_irq_vec <= 4'h0;
    end else if (vec_load) begin
      cpu_irq_req <= 1'b1;
      cpu_irq_vec <= pick.id;
    end else if (vec_take | vec_stale | ~global_en) begin
      cpu_irq_req <= 1'b0;
    end
  end

  // ---------------- assertions ----------------

  property p_port_set;
    @(posedge clk) disable iff (rst)
      pin_rise[3] |=> port_flags[3];
  endproperty
  a_port_set: assert property (p_port_set)
    else $error("pin 3 edge did not set its flag");

  property p_lv_set;
    @(posedge clk) disable iff (rst)
      lv_rise |=> port_flags[BIT_PIN7_LV];
  endproperty
  a_lv_set: assert property (p_lv_set)
    else $error("low voltage edge did not set bit 7");

  property p_cmp_set;
    @(posedge clk) disable iff (rst)
      cmp_rise |=> port_flags[BIT_PIN6_CMP];
  endproperty
  a_cmp_set: assert property (p_cmp_set)
    else $error("comparator edge did not set bit 6");

  property p_rx_set;
    @(posedge clk) disable iff (rst)
      periph_src.serial_rx |=> periph_flags[BIT_SERIAL_RX];
  endproperty
  a_rx_set: assert property (p_rx_set)
    else $error("serial rx request did not set bit 4");

  property p_vector;
    @(posedge clk) disable iff (rst)
      (global_en && pick.valid && !cpu_irq_req) |=>
        (cpu_irq_req && cpu_irq_vec == $past(pick.id));
  endproperty
  a_vector: assert property (p_vector)
    else $error("pending enabled request not vectored");

  property p_no_vector;
    @(posedge clk) disable iff (rst)
      !global_en |=> !cpu_irq_req;
  endproperty
  a_no_vector: assert property (p_no_vector)
    else $error("vector raised while globally disabled");

  property p_reset_clear;
    @(posedge clk)
      rst |=> (port_flags == 8'h00 && enable_high == 8'h00 && enable_low == 8'h00);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("registers not zero after reset");

  property p_enh_write;
    @(posedge clk) disable iff (rst)
      wr_enh |=> enable_high == $past(dat_i[7:0]);
  endproperty
  a_enh_write: assert property (p_enh_write)
    else $error("enable high write not stored");

  property p_enl_reserved;
    @(posedge clk) disable iff (rst)
      wr_enl |=> (enable_low[7] == 1'b0 && enable_low[2:1] == 2'h0 &&
                  enable_low[6:3] == $past(dat_i[6:3]));
  endproperty
  a_enl_reserved: assert property (p_enl_reserved)
    else $error("enable low write or reserved bits wrong");

  property p_ack_pulse;
    @(posedge clk) disable iff (rst)
      (bus_req && !ack_o) |=> ack_o ##1 !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("bus ack not a one-cycle answer");

  property p_pin7_set;
    @(posedge clk) disable iff (rst)
      pin_rise[7] |=> port_flags[BIT_PIN7_LV];
  endproperty
  a_pin7_set: assert property (p_pin7_set)
    else $error("pin 7 edge did not set bit 7");

  property p_pin6_set;
    @(posedge clk) disable iff (rst)
      pin_rise[6] |=> port_flags[BIT_PIN6_CMP];
  endproperty
  a_pin6_set: assert property (p_pin6_set)
    else $error("pin 6 edge did not set bit 6");

  property p_port_write;
    @(posedge clk) disable iff (rst)
      (wr_port && !vec_take) |=> port_flags == ($past(dat_i[7:0]) | $past(port_set));
  endproperty
  a_port_write: assert property (p_port_write)
    else $error("port flag write not stored");

  property p_poll_hold;
    @(posedge clk) disable iff (rst)
      (!global_en && !wr_perf && !vec_take) |=>
        (periph_flags & $past(periph_flags)) == $past(periph_flags);
  endproperty
  a_poll_hold: assert property (p_poll_hold)
    else $error("pending flag lost while polling");

  property p_vec_take;
    @(posedge clk) disable iff (rst)
      vec_take |=> !cpu_irq_req;
  endproperty
  a_vec_take: assert property (p_vec_take)
    else $error("vector still raised after acknowledge");

  property p_evt_sticky;
    @(posedge clk) disable iff (rst)
      (evt_status[EVT_PORT] && !rd_stat) |=> evt_status[EVT_PORT];
  endproperty
  a_evt_sticky: assert property (p_evt_sticky)
    else $error("event status bit dropped without a read");

  property p_stat_clear;
    @(posedge clk) disable iff (rst)
      (rd_stat && evt_set == 3'h0) |=> (evt_status & $past(dat_o[2:0])) == 3'h0;
  endproperty
  a_stat_clear: assert property (p_stat_clear)
    else $error("status read did not clear the bits it returned");

  property p_irq_level;
    @(posedge clk) disable iff (rst)
      irq == (|(evt_status & evt_mask));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("irq level differs from unmasked status");

  property p_dat_upper;
    @(posedge clk) disable iff (rst)
      ack_o |-> dat_o[31:8] == 24'h000000;
  endproperty
  a_dat_upper: assert property (p_dat_upper)
    else $error("read data upper bytes not zero");

endmodule // ireb_bank

`default_nettype wire

// *** ireb_pkg.sv ***
// Purpose: shared constants and types for the interrupt enable bank
// Assumes: one 25 MHz clock, synchronous active-high reset
// Notes:   register indices are word indices; byte address is four times the index
// Overview of operation
// - any source request sets its flag bit
// - globally enabled: pending request with nonzero level vectored to cpu
// - globally disabled: no vectoring, cpu polls flags
// - port flag bit 7: pin 7 or low voltage
// - port flag bit 6: pin 6 or comparator
// - port flag bits 5..0: pin of same index
// - port flag register read/write, reset zero
// - enable high: timers, serial rx/tx, converter
// - enable low: same positions, reset zero
// - peripheral flags: rx bit 4, tx 3, converter 0
`default_nettype none

package ireb_pkg;

  // register word indices
  localparam logic [11:0] IDX_PERIPH_FLAGS = 12'hfc0;
  localparam logic [11:0] IDX_ENABLE_HIGH  = 12'hfc1;
  localparam logic [11:0] IDX_ENABLE_LOW   = 12'hfc2;
  localparam logic [11:0] IDX_PORT_FLAGS   = 12'hfc3;
  localparam logic [11:0] IDX_EVT_STATUS   = 12'hfe0;
  localparam logic [11:0] IDX_EVT_MASK     = 12'hfe1;
  localparam logic [11:0] IDX_CONTROL      = 12'hfe2;

  // reset values
  localparam logic [7:0] RST_FLAGS  = 8'h00;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [2:0] RST_EVT    = 3'h0;
  localparam logic [0:0] RST_CTRL   = 1'h0;

  // peripheral and port flag field positions
  localparam int BIT_TIMER_B   = 6;
  localparam int BIT_TIMER_A   = 5;
  localparam int BIT_SERIAL_RX = 4;
  localparam int BIT_SERIAL_TX = 3;
  localparam int BIT_CONVERTER = 0;
  localparam int BIT_PIN7_LV   = 7;
  localparam int BIT_PIN6_CMP  = 6;

  // writable bits of the enable low and peripheral flag registers
  localparam logic [7:0] ENABLE_LOW_RW = 8'h79;
  localparam logic [7:0] PERIPH_USED   = 8'h79;

  // level given to every port flag when arbitrating
  localparam logic [1:0] PORT_LEVEL = 2'h1;

  // event status bit positions
  localparam int EVT_PORT   = 0;
  localparam int EVT_PERIPH = 1;
  localparam int EVT_VECTOR = 2;

  // synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 2;

  typedef struct packed {
    logic timer_b;
    logic timer_a;
    logic serial_rx;
    logic serial_tx;
    logic converter;
  } ireb_periph_src_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] id;
  } ireb_pick_t;

endpackage : ireb_pkg

`default_nettype wire

// *** ireb_prio_arbiter.sv ***
// Purpose: picks the pending request with the highest nonzero level
// Assumes: combinational, requests and levels from the same clock domain
// Notes:   ties go to the higher index
`timescale 1ns/1ps
`default_nettype none

module ireb_prio_arbiter
  import ireb_pkg::*;
(
  input  wire logic [15:0] req,
  input  wire logic [31:0] levels,
  output var  ireb_pick_t  pick
);

  // scan upward so later (higher index) wins ties
  always_comb begin
    logic [1:0] best;
    best = 2'h0;
    pick = '0;
    for (int i = 0; i < 16; i++) begin
      if (req[i] && (levels[2*i +: 2] != 2'h0) && (levels[2*i +: 2] >= best)) begin
        best       = levels[2*i +: 2];
        pick.valid = 1'b1;
        pick.id    = 4'(i);
      end
    end
  end

endmodule // ireb_prio_arbiter

`default_nettype wire

// *** ireb_cpu_model.sv ***
// Purpose: cpu core model that takes vectored requests and acknowledges them
// Assumes: same clock as the bank, one ack pulse per vector
// Notes:   records the first and the latest vector taken, and a count
`timescale 1ns/1ps
`default_nettype none

module ireb_cpu_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       ack_en,
  input  wire logic       cpu_irq_req,
  input  wire logic [3:0] cpu_irq_vec,
  output logic            cpu_irq_ack,
  output logic [3:0]      first_vec,
  output logic [3:0]      last_vec,
  output logic [7:0]      count
);
  // ack one cycle after a request is seen, never two cycles running
  always_ff @(posedge clk) begin
    if (rst) begin
      cpu_irq_ack <= 1'b0;
      first_vec   <= 4'h0;
      last_vec    <= 4'h0;
      count       <= 8'h00;
    end else if (cpu_irq_ack) begin
      cpu_irq_ack <= 1'b0;
    end else if (cpu_irq_req && ack_en) begin
      cpu_irq_ack <= 1'b1;
      last_vec    <= cpu_irq_vec;
      count       <= count + 8'h01;
      if (count == 8'h00) begin
        first_vec <= cpu_irq_vec;
      end
    end
  end
endmodule // ireb_cpu_model

`default_nettype wire

// *** tb.sv ***
// Purpose: self-checking bench for the interrupt enable bank
// Assumes: 25 MHz clock, synchronous reset held two cycles
// Notes:   register table rows first, then source and vector cases
`timescale 1ns/1ps
`default_nettype none

module tb
  import ireb_pkg::*;
;
  typedef struct packed {
    logic        w;
    logic [11:0] idx;
    logic [7:0]  d;
    logic [7:0]  e;
  } ireb_row_t;

  logic             clk = 1'b0;
  logic             rst = 1'b1;
  logic             cyc_i = 1'b0;
  logic             stb_i = 1'b0;
  logic             we_i = 1'b0;
  logic [13:0]      adr_i = 14'h0000;
  logic [3:0]       sel_i = 4'h0;
  logic [31:0]      dat_i = 32'h00000000;
  logic [31:0]      dat_o;
  logic             ack_o;
  logic [7:0]       port_pin = 8'h00;
  logic             low_volt = 1'b0;
  logic             cmp = 1'b0;
  ireb_periph_src_t src = '0;
  logic             cpu_irq_req;
  logic [3:0]       cpu_irq_vec;
  logic             cpu_irq_ack;
  logic             irq;
  logic             ack_en = 1'b0;
  logic [3:0]       first_vec;
  logic [3:0]       last_vec;
  logic [7:0]       count;
  logic [7:0]       q;
  int               errors = 0;
  int               comparisons = 0;
  ireb_row_t        rows [15];

  always #20 clk = ~clk;

  ireb_bank i_dut (.clk(clk), .rst(rst), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .port_pin(port_pin), .low_voltage_detector(low_volt), .comparator_out(cmp),
    .periph_src(src), .cpu_irq_req(cpu_irq_req), .cpu_irq_vec(cpu_irq_vec),
    .cpu_irq_ack(cpu_irq_ack), .irq(irq));

  ireb_cpu_model i_cpu (.clk(clk), .rst(rst), .ack_en(ack_en), .cpu_irq_req(cpu_irq_req),
    .cpu_irq_vec(cpu_irq_vec), .cpu_irq_ack(cpu_irq_ack), .first_vec(first_vec),
    .last_vec(last_vec), .count(count));

  // one classic wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [11:0] idx, input logic [7:0] d,
                    output logic [7:0] r);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'b00};
    dat_i <= {24'h000000, d};
    sel_i <= 4'h1;
    @(posedge clk);
    // only the watchdog ends a wait for ack
    while (ack_o !== 1'b1) begin
      @(posedge clk);
    end
    r = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic rd(input logic [11:0] idx, input logic [7:0] e, input string m);
    logic [7:0] r;
    wb(1'b0, idx, 8'h00, r);
    chk(r, e, m);
  endtask

  // one-cycle pulse on the peripheral sources
  task automatic pulse(input ireb_periph_src_t s);
    src <= s;
    @(posedge clk);
    src <= '0;
  endtask

  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // watchdog far beyond the expected run length
  initial begin
    #200us;
    errors++;
    $display("MISMATCH %0t watchdog", $time);
    test_done();
  end

  initial begin
    rows = '{
      '{1'b0, IDX_PERIPH_FLAGS, 8'h00, RST_FLAGS}, '{1'b0, IDX_ENABLE_HIGH, 8'h00, RST_ENABLE},
      '{1'b0, IDX_ENABLE_LOW, 8'h00, RST_ENABLE}, '{1'b0, IDX_PORT_FLAGS, 8'h00, RST_FLAGS},
      '{1'b0, IDX_CONTROL, 8'h00, 8'h00}, '{1'b1, IDX_ENABLE_HIGH, 8'h79, 8'h79},
      '{1'b1, IDX_ENABLE_HIGH, 8'h00, 8'h00}, '{1'b1, IDX_ENABLE_LOW, 8'h79, ENABLE_LOW_RW},
      '{1'b1, IDX_ENABLE_LOW, 8'h00, 8'h00}, '{1'b1, IDX_PORT_FLAGS, 8'ha5, 8'ha5},
      '{1'b1, IDX_PORT_FLAGS, 8'h5a, 8'h5a}, '{1'b1, IDX_PORT_FLAGS, 8'h00, 8'h00},
      '{1'b1, IDX_PERIPH_FLAGS, 8'h79, PERIPH_USED}, '{1'b1, IDX_PERIPH_FLAGS, 8'h00, 8'h00},
      '{1'b1, 12'hfff, 8'hff, 8'h00}};
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset values, read/write and the unmapped word
    foreach (rows[i]) begin
      if (rows[i].w) wb(1'b1, rows[i].idx, rows[i].d, q);
      rd(rows[i].idx, rows[i].e, "register row");
    end
    $display("test registers done");
    // pin, low-voltage and comparator events while globally disabled
    port_pin <= 8'h61;
    low_volt <= 1'b1;
    repeat (6) @(posedge clk);
    rd(IDX_PORT_FLAGS, 8'he1, "pins 6 5 0 and low voltage");
    wb(1'b1, IDX_PORT_FLAGS, 8'h00, q);
    port_pin <= 8'he1;
    cmp <= 1'b1;
    repeat (6) @(posedge clk);
    rd(IDX_PORT_FLAGS, 8'hc0, "pin 7 and comparator");
    wb(1'b1, IDX_PORT_FLAGS, 8'h00, q);
    $display("test port events done");
    // polled operation, nothing vectored
    wb(1'b1, IDX_ENABLE_LOW, 8'h20, q);
    pulse('{1'b1, 1'b1, 1'b0, 1'b1, 1'b0});
    repeat (4) @(posedge clk);
    chk({7'h00, cpu_irq_req}, 8'h00, "vector while disabled");
    rd(IDX_PERIPH_FLAGS, 8'h68, "polled flags");
    wb(1'b1, IDX_PERIPH_FLAGS, 8'h00, q);
    wb(1'b0, IDX_EVT_STATUS, 8'h00, q);
    $display("test polled done");
    // vectored by level: rx level 3, converter 1, timer a 0
    wb(1'b1, IDX_ENABLE_HIGH, 8'h10, q);
    wb(1'b1, IDX_ENABLE_LOW, 8'h11, q);
    ack_en <= 1'b1;
    wb(1'b1, IDX_CONTROL, 8'h01, q);
    pulse('{1'b0, 1'b1, 1'b1, 1'b0, 1'b1});
    repeat (12) @(posedge clk);
    chk({4'h0, first_vec}, 8'h04, "first vector rx");
    chk({4'h0, last_vec}, 8'h00, "second vector converter");
    chk(count, 8'h02, "vector count");
    rd(IDX_PERIPH_FLAGS, 8'h20, "level zero left pending");
    $display("test vectored done");
    // event status, mask and the level interrupt
    chk({7'h00, irq}, 8'h00, "irq masked");
    wb(1'b1, IDX_EVT_MASK, 8'h04, q);
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h01, "irq unmasked");
    rd(IDX_EVT_STATUS, 8'h06, "event status");
    repeat (2) @(posedge clk);
    chk({7'h00, irq}, 8'h00, "irq after read clear");
    $display("test events done");
    // mid-run reset with pins, low voltage and comparator still high
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    chk({7'h00, cpu_irq_req}, 8'h00, "vector after reset");
    chk({7'h00, irq}, 8'h00, "irq after reset");
    rd(IDX_PORT_FLAGS, RST_FLAGS, "no false edge after reset");
    rd(IDX_ENABLE_HIGH, RST_ENABLE, "enable high after reset");
    rd(IDX_CONTROL, 8'h00, "global enable after reset");
    $display("test reset done");
    test_done();
  end
endmodule // tb

`default_nettype wire
